//--- logic/adcsq_ctrl.sv
// converter sequencer: registers, converter clock, pin takeover
// assumes single-cycle strobes; the comparator is analog and outside
`timescale 1ns/1ns

// Function
// - each conversion yields an unsigned 8-bit result
// - one converter serves 15 pins through a channel-steered mux
// - finished conversion loads data, then sets flag or interrupts
// - the selected pin is forced to be a converter input
// - unselected pins stay under normal port control
// - port data and direction writes skip the selected pin
// - reading a selected pin gives 0 if input, else the data latch
// - high reference gives full scale, ground gives zero, linear between
// - a status write starts a conversion of 16 to 17 converter clocks
// - converter clock is oscillator or bus clock through a prescaler
// - channel field of 5 bits; all ones powers off and is reset value
// - irq off: done flag sets; status write or data read clears
// - continuous bit repeats conversions, else one conversion
// - irq on: request at end; data read or status write clears
module adcsq_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [7:0] bus_rdata,
    input wire logic oscillator_clock,
    input wire logic comparator_high,
    input wire logic [14:0] pin_in,
    output logic [14:0] pin_out,
    output logic [14:0] pin_oe_n,
    output logic [4:0] channel_select_field,
    output logic [7:0] converter_trial,
    output logic converter_powered,
    output logic irq_req
);
    adcsq_sar_if sar ();

    logic flag_reg;
    logic irq_en_reg;
    logic cont_reg;
    logic [4:0] chan_reg;
    logic [7:0] data_reg;
    logic clk_sel_reg;
    logic [2:0] presc_reg;
    logic [3:0] pre_cnt_reg;
    logic tick_reg;
    logic [14:0] latch_reg;
    logic [14:0] dir_reg;
    logic [14:0] oe_n_reg;
    logic [14:0] sel_vec;
    logic [14:0] port_view;
    logic [7:0] rdata_reg;
    logic powered_reg;
    logic irq_reg;
    logic [3:0] div_mask;
    logic src_en;
    logic wr_status;
    logic rd_data;
    logic wr_chan_on;
    logic restart;
    logic [4:0] tick_seen_reg;

    // ********************************
    // bus decode
    // ********************************
    assign wr_status = bus_write && bus_addr == adcsq_pkg::ADDR_STATUS;
    assign rd_data = bus_read && bus_addr == adcsq_pkg::ADDR_DATA;
    assign wr_chan_on = wr_status && bus_wdata[4:0] != adcsq_pkg::CHAN_OFF;
    assign restart = sar.done && cont_reg
        && chan_reg != adcsq_pkg::CHAN_OFF;

    // ********************************
    // status and control register
    // ********************************
    // mode bits and channel; reset leaves the converter off
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_en_reg <= adcsq_pkg::STATUS_RESET[adcsq_pkg::IRQEN_BIT];
            cont_reg <= adcsq_pkg::STATUS_RESET[adcsq_pkg::CONT_BIT];
            chan_reg <= adcsq_pkg::STATUS_RESET[4:0];
        end else if (wr_status) begin
            irq_en_reg <= bus_wdata[adcsq_pkg::IRQEN_BIT];
            cont_reg <= bus_wdata[adcsq_pkg::CONT_BIT];
            chan_reg <= bus_wdata[4:0];
        end
    end

    // done flag: completion wins over a same-cycle clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_reg <= adcsq_pkg::STATUS_RESET[adcsq_pkg::FLAG_BIT];
        end else if (sar.done && !irq_en_reg) begin
            flag_reg <= 1'b1;
        end else if (wr_status) begin
            // set only by a write that also sets the interrupt enable bit
            flag_reg <= bus_wdata[adcsq_pkg::FLAG_BIT]
                && bus_wdata[adcsq_pkg::IRQEN_BIT];
        end else if (rd_data && !irq_en_reg) begin
            flag_reg <= 1'b0;
        end
    end

    // interrupt request: completion wins over a same-cycle clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else if (sar.done && irq_en_reg) begin
            irq_reg <= 1'b1;
        end else if (wr_status || rd_data) begin
            irq_reg <= 1'b0;
        end
    end

    // only the finished code is ever stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_reg <= 8'h00;
        end else if (sar.done) begin
            data_reg <= sar.result;
        end
    end

    // ********************************
    // converter clock
    // ********************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_sel_reg <= adcsq_pkg::CLOCK_RESET[adcsq_pkg::CLKSEL_BIT];
            presc_reg <= adcsq_pkg::CLOCK_RESET[7:5];
        end else if (bus_write && bus_addr == adcsq_pkg::ADDR_CLOCK) begin
            clk_sel_reg <= bus_wdata[adcsq_pkg::CLKSEL_BIT];
            presc_reg <= bus_wdata[adcsq_pkg::PRESC_LSB +: 3];
        end
    end

    // divide by 1, 2, 4, 8 or 16; codes above 4 saturate
    assign div_mask = (presc_reg >= adcsq_pkg::PRESC_MAX) ? 4'hF
        : 4'((5'h01 << presc_reg) - 5'h01);
    assign src_en = clk_sel_reg ? 1'b1 : oscillator_clock;

    // free running, so the first tick after a start lands anywhere
    // within one converter clock: hence 16 to 17 clocks per conversion
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pre_cnt_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (src_en) begin
                if (pre_cnt_reg >= div_mask) begin
                    pre_cnt_reg <= 4'h0;
                    tick_reg <= 1'b1;
                end else begin
                    pre_cnt_reg <= pre_cnt_reg + 4'h1;
                end
            end
        end
    end

    // ********************************
    // approximation engine
    // ********************************
    // a write restarts; a power-off write aborts
    always_comb begin
        sar.start = wr_chan_on || (restart && !wr_status);
        sar.abort = wr_status && !wr_chan_on;
        sar.tick = tick_reg;
        sar.comp_above = comparator_high;
    end

    adcsq_sar u_sar (
        .clk_sys(clk_sys),
        .rst(rst),
        .sar(sar.engine)
    );

    // ********************************
    // shared port pins
    // ********************************
    // one generate loop per pin: takeover, masked writes, read view
    for (genvar i = 0; i < adcsq_pkg::NUM_CHAN; i++) begin : g_pin
        localparam logic [7:0] LATCH_ADDR = (i < 8)
            ? adcsq_pkg::ADDR_PORT_LO : adcsq_pkg::ADDR_PORT_HI;
        localparam logic [7:0] DIR_ADDR = (i < 8)
            ? adcsq_pkg::ADDR_DIR_LO : adcsq_pkg::ADDR_DIR_HI;
        localparam int LANE = i % 8;

        assign sel_vec[i] = chan_reg == 5'(i);

        // selected pin ignores port writes
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                latch_reg[i] <= 1'b0;
                dir_reg[i] <= 1'b0;
            end else if (!sel_vec[i]) begin
                if (bus_write && bus_addr == LATCH_ADDR) begin
                    latch_reg[i] <= bus_wdata[LANE];
                end
                if (bus_write && bus_addr == DIR_ADDR) begin
                    dir_reg[i] <= bus_wdata[LANE];
                end
            end
        end

        // selected pin is released to the analog input
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                oe_n_reg[i] <= 1'b1;
            end else begin
                oe_n_reg[i] <= sel_vec[i] || !dir_reg[i];
            end
        end

        // digital read of a converter pin never sees the analog level
        assign port_view[i] = dir_reg[i] ? latch_reg[i]
            : (sel_vec[i] ? 1'b0 : pin_in[i]);
    end

    // ********************************
    // read port
    // ********************************
    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst || !bus_read) begin
            rdata_reg <= 8'h00;
        end else begin
            unique case (bus_addr)
                adcsq_pkg::ADDR_STATUS:
                    rdata_reg <= {flag_reg, irq_en_reg, cont_reg, chan_reg};
                adcsq_pkg::ADDR_DATA: rdata_reg <= data_reg;
                adcsq_pkg::ADDR_CLOCK:
                    rdata_reg <= {presc_reg, clk_sel_reg, 4'h0};
                adcsq_pkg::ADDR_PORT_LO: rdata_reg <= port_view[7:0];
                adcsq_pkg::ADDR_PORT_HI: rdata_reg <= {1'b0, port_view[14:8]};
                adcsq_pkg::ADDR_DIR_LO: rdata_reg <= dir_reg[7:0];
                adcsq_pkg::ADDR_DIR_HI: rdata_reg <= {1'b0, dir_reg[14:8]};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // power state mirrors the channel field
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            powered_reg <= 1'b0;
        end else begin
            powered_reg <= chan_reg != adcsq_pkg::CHAN_OFF;
        end
    end

    assign bus_rdata = rdata_reg;
    assign pin_out = latch_reg;
    assign pin_oe_n = oe_n_reg;
    assign channel_select_field = chan_reg;
    assign converter_trial = sar.trial;
    assign converter_powered = powered_reg;
    assign irq_req = irq_reg;

    // ********************************
    // checks
    // ********************************
    // converter clocks counted since the last start
    always_ff @(posedge clk_sys) begin
        if (rst || sar.start) begin
            tick_seen_reg <= 5'h00;
        end else if (tick_reg && sar.busy) begin
            tick_seen_reg <= tick_seen_reg + 5'h01;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    result_load_a: assert property (
        sar.done |=> data_reg == $past(sar.result))
        else $error("finished result not loaded");
    data_hold_a: assert property (
        $changed(data_reg) |-> $past(sar.done))
        else $error("data register changed without a finished result");
    flag_set_a: assert property (
        sar.done && !irq_en_reg |=> flag_reg && !irq_reg)
        else $error("done flag not set by completion");
    flag_clear_a: assert property (
        rd_data && !sar.done && !irq_en_reg |=> !flag_reg)
        else $error("data read did not clear done flag");
    irq_set_a: assert property (
        sar.done && irq_en_reg |=> irq_req ##1 (irq_req || $past(wr_status)
        || $past(rd_data)))
        else $error("interrupt request missing or dropped early");
    start_busy_a: assert property (
        wr_chan_on |=> sar.busy && tick_seen_reg == 5'h00)
        else $error("status write did not start a conversion");
    conv_len_a: assert property (
        sar.done |-> tick_seen_reg == adcsq_pkg::CONV_TICKS)
        else $error("conversion took the wrong number of ticks");
    repeat_a: assert property (
        restart && !wr_status |=> sar.busy)
        else $error("continuous mode did not restart");
    power_off_a: assert property (
        chan_reg == adcsq_pkg::CHAN_OFF |-> !sar.busy)
        else $error("converter busy while powered off");
    pin_keep_a: assert property (
        ((latch_reg ^ $past(latch_reg)) & $past(sel_vec)) == 15'h0000)
        else $error("port write reached the converter pin");
    pin_release_a: assert property (
        ##1 (pin_oe_n & $past(sel_vec)) == $past(sel_vec))
        else $error("converter pin still driven");
    pin_read_a: assert property (
        bus_read && bus_addr == adcsq_pkg::ADDR_PORT_LO
        |=> (bus_rdata & $past(sel_vec[7:0] & ~dir_reg[7:0])) == 8'h00)
        else $error("converter pin read as nonzero input");
endmodule

//--- logic/adcsq_pkg.sv
// constants shared by the converter sequencer and its approximation engine
// assumes an 8-bit register port sampled on the rising edge of clk_sys
package adcsq_pkg;
    // ********************************
    // register addresses
    // ********************************
    localparam logic [7:0] ADDR_STATUS = 8'h38;
    localparam logic [7:0] ADDR_DATA = 8'h39;
    localparam logic [7:0] ADDR_CLOCK = 8'h3A;
    localparam logic [7:0] ADDR_PORT_LO = 8'h40;
    localparam logic [7:0] ADDR_PORT_HI = 8'h41;
    localparam logic [7:0] ADDR_DIR_LO = 8'h44;
    localparam logic [7:0] ADDR_DIR_HI = 8'h45;
    // ********************************
    // fields and reset values
    // ********************************
    localparam int FLAG_BIT = 7;
    localparam int IRQEN_BIT = 6;
    localparam int CONT_BIT = 5;
    localparam int CLKSEL_BIT = 4;
    localparam int PRESC_LSB = 5;
    localparam int NUM_CHAN = 15;
    localparam logic [7:0] STATUS_RESET = 8'h1F;
    localparam logic [7:0] CLOCK_RESET = 8'h00;
    localparam logic [4:0] CHAN_OFF = 5'h1F;
    localparam logic [2:0] PRESC_MAX = 3'h4;
    // ********************************
    // conversion timing in converter clocks, and the first trial code
    // ********************************
    localparam logic [4:0] SAMPLE_LAST = 5'h07;
    localparam logic [4:0] CONV_LAST = 5'h0F;
    localparam logic [4:0] CONV_TICKS = 5'h11;
    // arm value: wraps to zero on the partial first tick after a start
    localparam logic [4:0] STEP_ARM = 5'h1F;
    localparam logic [7:0] TRIAL_START = 8'h80;
    typedef enum logic [2:0] {
        SAR_IDLE = 3'h1,
        SAR_SAMPLE = 3'h2,
        SAR_RESOLVE = 3'h4
    } adcsq_state_t;
endpackage

//--- logic/adcsq_sar.sv
// successive approximation engine: sample phase, then one bit per tick
// assumes tick is a one-cycle enable and comp_above is synchronous
`timescale 1ns/1ns
module adcsq_sar (
    input wire logic clk_sys,
    input wire logic rst,
    adcsq_sar_if.engine sar
);
    adcsq_pkg::adcsq_state_t state_reg;
    logic [4:0] step_reg;
    logic [7:0] trial_reg;
    logic [7:0] trial_next;
    logic [7:0] result_reg;
    logic done_reg;
    logic [2:0] bit_idx;
    logic last_tick;

    // ********************************
    // bit resolution
    // ********************************
    // steps 8..15 map onto bits 7..0
    assign bit_idx = ~step_reg[2:0];
    assign last_tick = sar.tick && state_reg == adcsq_pkg::SAR_RESOLVE
        && step_reg == adcsq_pkg::CONV_LAST;

    // keep or drop the bit on trial, then try the next lower one
    always_comb begin
        trial_next = trial_reg;
        trial_next[bit_idx] = sar.comp_above;
        if (bit_idx != 3'h0) begin
            trial_next[bit_idx - 3'h1] = 1'b1;
        end
    end

    // ********************************
    // sequencing
    // ********************************
    // start beats abort so a rewrite restarts cleanly
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= adcsq_pkg::SAR_IDLE;
        end else if (sar.start) begin
            state_reg <= adcsq_pkg::SAR_SAMPLE;
        end else if (sar.abort) begin
            state_reg <= adcsq_pkg::SAR_IDLE;
        end else if (sar.tick) begin
            unique case (state_reg)
                adcsq_pkg::SAR_IDLE: begin
                    state_reg <= adcsq_pkg::SAR_IDLE;
                end
                adcsq_pkg::SAR_SAMPLE: begin
                    if (step_reg == adcsq_pkg::SAMPLE_LAST) begin
                        state_reg <= adcsq_pkg::SAR_RESOLVE;
                    end
                end
                adcsq_pkg::SAR_RESOLVE: begin
                    if (step_reg == adcsq_pkg::CONV_LAST) begin
                        state_reg <= adcsq_pkg::SAR_IDLE;
                    end
                end
            endcase
        end
    end

    // converter clock count within one conversion; the first tick after a
    // start is only a partial converter clock, so it is spent settling and
    // the conversion spans 16 to 17 full converter clocks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_reg <= 5'h00;
        end else if (sar.start) begin
            step_reg <= adcsq_pkg::STEP_ARM;
        end else if (sar.abort) begin
            step_reg <= 5'h00;
        end else if (sar.tick && state_reg != adcsq_pkg::SAR_IDLE) begin
            step_reg <= step_reg + 5'h01;
        end
    end

    // trial code drives the comparator reference
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trial_reg <= 8'h00;
        end else if (sar.start) begin
            trial_reg <= adcsq_pkg::TRIAL_START;
        end else if (!sar.abort && sar.tick
                && state_reg == adcsq_pkg::SAR_RESOLVE) begin
            trial_reg <= trial_next;
        end
    end

    // finished code and a one-cycle done pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            done_reg <= last_tick && !sar.start && !sar.abort;
            if (last_tick && !sar.start && !sar.abort) begin
                result_reg <= trial_next;
            end
        end
    end

    assign sar.trial = trial_reg;
    assign sar.result = result_reg;
    assign sar.done = done_reg;
    assign sar.busy = state_reg != adcsq_pkg::SAR_IDLE;

    // ********************************
    // checks
    // ********************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    msb_first_a: assert property (
        state_reg == adcsq_pkg::SAR_RESOLVE && step_reg == 5'h08
        |-> trial_reg == adcsq_pkg::TRIAL_START)
        else $error("first resolve step is not the top bit");
    done_pulse_a: assert property (
        done_reg |-> $past(state_reg) == adcsq_pkg::SAR_RESOLVE
        && !sar.busy)
        else $error("done without a finished resolve phase");
endmodule

//--- logic/adcsq_sar_if.sv
// link between the sequencer and the approximation engine
// assumes both ends run on clk_sys
`timescale 1ns/1ns
interface adcsq_sar_if;
    logic start;
    logic abort;
    logic tick;
    logic comp_above;
    logic done;
    logic busy;
    logic [7:0] trial;
    logic [7:0] result;
    modport ctrl (
        output start, abort, tick, comp_above,
        input done, busy, trial, result
    );
    modport engine (
        input start, abort, tick, comp_above,
        output done, busy, trial, result
    );
endinterface

//--- tb/adcsq_analog_model.sv
// analog side of the converter: comparator and shared pin wiring
// assumes one level per channel, eight bits each, packed low first
`timescale 1ns/1ns
module adcsq_analog_model (
    input wire logic clk_sys,
    input wire logic [119:0] levels,
    input wire logic [4:0] channel_select_field,
    input wire logic [7:0] converter_trial,
    input wire logic converter_powered,
    input wire logic [14:0] pin_out,
    input wire logic [14:0] pin_oe_n,
    output logic comparator_high,
    output logic [14:0] pin_in
);
    // ********************************
    // comparator and pins
    // ********************************
    logic wiggle = 1'b0;
    logic [7:0] level;
    // an undriven line flips each cycle so no stale value passes for data
    always @(posedge clk_sys) wiggle <= ~wiggle;
    // mux picks one channel; codes past 14 read as ground here
    always_comb begin
        level = 8'h00;
        if (channel_select_field < 5'h0F) begin
            level = levels[8 * channel_select_field +: 8];
        end
    end
    // straight-line compare; an unpowered comparator gives junk
    assign comparator_high = converter_powered ?
        (level >= converter_trial) : wiggle;
    // driven pins echo the latch, released or analog ones wander
    always_comb begin
        for (int i = 0; i < 15; i++) begin
            pin_in[i] = pin_oe_n[i] ? wiggle ^ i[0] : pin_out[i];
        end
    end
endmodule

//--- tb/adcsq_ctrl_tb.sv
// bench for the converter sequencer: registers, timing, pin takeover
// assumes the analog model stands in for comparator and pin wiring
`timescale 1ns/1ns
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); \
    end \
end
module adcsq_ctrl_tb;
    // ********************************
    // signals and instances
    // ********************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [7:0] bus_rdata;
    logic oscillator_clock = 1'b0;
    logic comparator_high;
    logic [14:0] pin_in;
    logic [14:0] pin_out;
    logic [14:0] pin_oe_n;
    logic [4:0] channel_select_field;
    logic [7:0] converter_trial;
    logic converter_powered;
    logic irq_req;
    logic [119:0] levels = '0;
    logic [7:0] rd_val;
    logic [7:0] last_res = 8'h00;
    int err_total = 0;
    int tests_run = 0;
    always #5 clk_sys = ~clk_sys;
    // oscillator enable on every second cycle: half the bus rate
    always @(posedge clk_sys) oscillator_clock <= ~oscillator_clock;
    adcsq_ctrl uut (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .oscillator_clock(oscillator_clock),
        .comparator_high(comparator_high), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .channel_select_field(channel_select_field),
        .converter_trial(converter_trial),
        .converter_powered(converter_powered), .irq_req(irq_req));
    adcsq_analog_model analog (.clk_sys(clk_sys), .levels(levels),
        .channel_select_field(channel_select_field),
        .converter_trial(converter_trial),
        .converter_powered(converter_powered), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .comparator_high(comparator_high),
        .pin_in(pin_in));
    // ********************************
    // bus cycles and helpers
    // ********************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clk_sys);
        bus_write <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clk_sys);
        bus_read <= 1'b0;
        #1 rd_val = bus_rdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        `CHK(rd_val, e)
    endtask
    task automatic set_level(input int ch, input logic [7:0] v);
        levels[ch * 8 +: 8] <= v;
    endtask
    // one conversion; the mid-way peek must still see the old result
    task automatic convert(input logic [7:0] ctl, input int div,
        input logic [7:0] exp);
        time t0;
        int cyc;
        wr(8'h38, ctl);
        t0 = $time;
        repeat (12 * div) @(posedge clk_sys);
        chk_rd(8'h39, last_res);
        rd_val = 8'h00;
        for (int i = 0; i < 200 && rd_val[7] !== 1'b1; i++) rd(8'h38);
        cyc = int'(($time - t0) / 10);
        `CHK(cyc >= 16 * div && cyc <= 17 * div + 6, 1'b1)
        chk_rd(8'h39, exp);
        chk_rd(8'h38, ctl);
        `CHK(irq_req, 1'b0)
        last_res = exp;
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        `CHK(channel_select_field, 5'h1F)
        `CHK(converter_powered, 1'b0)
        `CHK(pin_oe_n, 15'h7FFF)
        `CHK(pin_out, 15'h0000)
        `CHK(converter_trial, 8'h00)
        `CHK(irq_req, 1'b0)
        chk_rd(8'h38, 8'h1F);
        chk_rd(8'h39, 8'h00);
        chk_rd(8'h3A, 8'h00);
        chk_rd(8'h50, 8'h00);
    endtask
    // no timer clocks run here, so channels 12 and 14 are fair game
    task automatic t_single();
        int chs[4] = '{3, 0, 14, 9};
        logic [7:0] vals[4] = '{8'hA5, 8'hFF, 8'h00, 8'h5A};
        wr(8'h3A, 8'h10);
        for (int i = 0; i < 4; i++) begin
            set_level(chs[i], vals[i]);
            convert({3'h0, chs[i][4:0]}, 1, vals[i]);
        end
    endtask
    // prescaler on the bus clock, then the oscillator source
    task automatic t_clock();
        // codes past 4 saturate at a divide by 16
        for (int p = 0; p < 6; p++) begin
            wr(8'h3A, {p[2:0], 5'h10});
            set_level(3, {5'h08, p[2:0]});
            convert(8'h03, p > 4 ? 16 : 1 << p, {5'h08, p[2:0]});
        end
        wr(8'h3A, 8'h00);
        set_level(3, 8'hC3);
        convert(8'h03, 2, 8'hC3);
        wr(8'h3A, 8'h10);
    endtask
    task automatic t_irq();
        set_level(5, 8'h77);
        wr(8'h38, 8'h45);
        for (int i = 0; i < 60 && irq_req !== 1'b1; i++) @(posedge clk_sys);
        `CHK(irq_req, 1'b1)
        chk_rd(8'h38, 8'h45);
        chk_rd(8'h39, 8'h77);
        `CHK(irq_req, 1'b0)
        wr(8'h38, 8'h45);
        for (int i = 0; i < 60 && irq_req !== 1'b1; i++) @(posedge clk_sys);
        `CHK(irq_req, 1'b1)
        wr(8'h38, 8'h1F);
        #1 `CHK(irq_req, 1'b0)
        last_res = 8'h77;
    endtask
    // repeats follow a moving input until the channel is powered off
    task automatic t_cont();
        set_level(7, 8'h12);
        wr(8'h38, 8'h27);
        repeat (40) @(posedge clk_sys);
        set_level(7, 8'hE1);
        repeat (60) @(posedge clk_sys);
        chk_rd(8'h39, 8'hE1);
        // stay clear of a completion, which would win over the clear
        repeat (45) @(posedge clk_sys);
        wr(8'h38, 8'h1F);
        set_level(7, 8'h33);
        chk_rd(8'h38, 8'h1F);
        `CHK(converter_powered, 1'b0)
        repeat (60) @(posedge clk_sys);
        chk_rd(8'h39, 8'hE1);
    endtask
    task automatic t_pins();
        wr(8'h44, 8'hFF);
        wr(8'h40, 8'hFF);
        repeat (2) @(posedge clk_sys);
        `CHK(pin_oe_n[7:0], 8'h00)
        `CHK(pin_out[7:0], 8'hFF)
        wr(8'h38, 8'h03);
        wr(8'h40, 8'h00);
        repeat (2) @(posedge clk_sys);
        `CHK(pin_oe_n[7:0], 8'h08)
        `CHK(pin_out[7:0], 8'h08)
        chk_rd(8'h40, 8'h08);
        wr(8'h44, 8'h00);
        repeat (2) @(posedge clk_sys);
        `CHK(pin_oe_n[7:0], 8'hFF)
        rd(8'h40);
        `CHK(rd_val[3], 1'b1)
        wr(8'h38, 8'h09);
        repeat (2) @(posedge clk_sys);
        `CHK(pin_oe_n[9], 1'b1)
        rd(8'h41);
        `CHK(rd_val[1], 1'b0)
    endtask
    // ********************************
    // sequence and verdict
    // ********************************
    task automatic results();
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_single();
        t_clock();
        t_irq();
        t_cont();
        t_pins();
        results();
    end
    // a hang costs far more than the under two thousand cycles of the run
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule
